// ==== design/djb_drive_ctrl.sv ====
// Jog, external DC brake and multi-speed slot control with an APB register slave
// What this block does
// - Jog output frequency capped at 10 Hz
// - Jog input plus run outputs jog frequency
// - Keypad run triggers jog only in terminal mode
// - Jog ends by coast, ramp or DC brake
// - No jog below start frequency or zero
// - Terminal code 06 is the jog input
// - Terminal code 07 is the brake input
// - Brake delay setting 0.0 to 5.0 s
// - Brake force 0 to 100 percent scales braking
// - Terminal run resumes ramp after brake release
// - Keypad run stays off after brake release
// - Coast during delay, then brake
// - Monitor shows present output frequency
// - Store key saves edited frequency to slot while stopped
// - Sixteen slots, each directly editable
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/100ps
module djb_drive_ctrl
   import djb_pkg::*;
#(
   parameter int RAMP_TICK_CYC = RAMP_TICK_CYCLES
)(
   input  wire logic        ref_clk_in,      // 25 MHz clock
   input  wire logic        rst_n_in,        // Async reset, active low
   input  wire logic        psel_in,         // APB select
   input  wire logic        penable_in,      // APB enable
   input  wire logic        pwrite_in,       // APB write
   input  wire logic [7:0]  paddr_in,        // APB byte address
   input  wire logic [31:0] pwdata_in,       // APB write data
   input  wire logic [4:0]  term_in,         // Input terminals one to five
   input  wire logic        forward_run_in,  // Forward run pin
   input  wire logic        reverse_run_in,  // Reverse run pin
   output logic      [31:0] prdata_out,      // APB read data
   output logic             pready_out,      // APB ready
   output logic             pslverr_out,     // APB error
   output logic      [11:0] freq_out,        // Output frequency, 0.1 Hz
   output logic             run_out,         // Inverter output active
   output logic      [6:0]  brake_level_out  // DC brake effort, percent
);
   function automatic logic fn_hit(input logic [29:0] f, input logic [4:0] p, input logic [5:0] c);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 5; i++)
      begin
         hit = hit | (p[i] & (f[6*i +: 6] == c));
      end
      return hit;
   endfunction

   function automatic logic [11:0] fn_step(input logic [11:0] cur, input logic [11:0] tgt);
      logic [11:0] r;
      r = cur;
      if (cur < tgt)
      begin
         r = cur + 12'h001;
      end
      else if (cur > tgt)
      begin
         r = cur - 12'h001;
      end
      return r;
   endfunction

   logic [6:0]    s1_r, s2_r, s3_r, pin_r, pin_nxt;
   logic [1:0]    src_r, src_nxt, meth_r, meth_nxt;
   logic [11:0]   jogf_r, jogf_nxt, startf_r, startf_nxt, oset_r, oset_nxt;
   logic [5:0]    dly_r, dly_nxt, cnt_r, cnt_nxt;
   logic [6:0]    force_r, force_nxt, lvl_r, lvl_nxt;
   logic [29:0]   tfn_r, tfn_nxt;
   logic [11:0]   slot_r [16];
   logic          slot_we;
   logic [3:0]    slot_idx;
   logic [11:0]   slot_dat;
   djb_state_type st_r, st_nxt;
   logic [11:0]   freq_r, freq_nxt;
   logic          timed_r, timed_nxt, key_run_r, key_run_nxt, run_r, run_nxt;
   logic [14:0]   ms_r, ms_nxt;
   logic [6:0]    tenth_r, tenth_nxt;
   logic [31:0]   prdata_r, prdata_nxt;
   logic          jog_t, brk_t, term_run, key_ok, run_req, jog_ok, ms_tick, tenth_tick;
   logic          wr, setup, mapped, key_w, key_clr, div_clr;
   logic [3:0]    sel;
   logic [11:0]   jog_lim, target;

   // Input pins: three stages, a change counts once stages two and three agree
   assign pin_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & pin_r);

   always_comb
   begin
      jog_t = fn_hit(tfn_r, pin_r[4:0], FN_JOG);
      brk_t = fn_hit(tfn_r, pin_r[4:0], FN_BRAKE);
      for (int i = 0; i < 4; i++)
      begin
         sel[i] = fn_hit(tfn_r, pin_r[4:0], FN_SEL0 + 6'(i));
      end
   end

   assign term_run = (src_r == SRC_TERMINAL) & (pin_r[5] | pin_r[6]);
   // Keypad source with jog on gives no request, so keypad run never starts a jog there
   assign key_ok   = key_run_r & (((src_r == SRC_KEYPAD) & ~jog_t) | ((src_r == SRC_TERMINAL) & jog_t));
   assign run_req  = term_run | key_ok;
   assign jog_ok   = (jogf_r != 12'h000) & (jogf_r >= startf_r);
   assign jog_lim  = (jogf_r > JOG_LIMIT) ? JOG_LIMIT : jogf_r;
   assign target   = slot_r[sel];
   assign ms_tick  = (ms_r == 15'(RAMP_TICK_CYC - 1));
   assign tenth_tick = ms_tick & (tenth_r == 7'(TICKS_PER_TENTH - 1));
   // Divider restarts on brake entry so a delay never expires early
   assign div_clr   = ((st_nxt == ST_WAIT) | (st_nxt == ST_BRAKE)) & (st_r != ST_WAIT) & (st_r != ST_BRAKE);
   assign ms_nxt    = (ms_tick | div_clr) ? 15'h0000 : ms_r + 15'h0001;
   assign tenth_nxt = (tenth_tick | div_clr) ? 7'h00 : (ms_tick ? tenth_r + 7'h01 : tenth_r);

   assign setup  = psel_in & ~penable_in;
   assign wr     = psel_in & penable_in & pwrite_in;
   assign key_w  = wr & (paddr_in == ADDR_KEY);
   assign mapped = (paddr_in[1:0] == 2'h0) & ((paddr_in[7:6] == SLOT_PAGE) | (paddr_in <= ADDR_KEY));
   assign pready_out  = 1'b1;
   assign pslverr_out = psel_in & penable_in & ~mapped;
   assign prdata_out  = prdata_r;
   assign freq_out    = freq_r;
   assign run_out     = run_r;
   assign brake_level_out = lvl_r;

   // Registers written over APB and the keypad actions
   always_comb
   begin
      src_nxt    = src_r;
      meth_nxt   = meth_r;
      jogf_nxt   = jogf_r;
      startf_nxt = startf_r;
      dly_nxt    = dly_r;
      force_nxt  = force_r;
      oset_nxt   = oset_r;
      tfn_nxt    = tfn_r;
      slot_we    = 1'b0;
      slot_idx   = paddr_in[5:2];
      slot_dat   = pwdata_in[11:0];
      if (wr & mapped)
      begin
         case (paddr_in)
            ADDR_CTRL:
            begin
               src_nxt  = pwdata_in[SRC_LSB +: 2];
               meth_nxt = pwdata_in[METH_LSB +: 2];
            end
            ADDR_JOGF:   jogf_nxt   = pwdata_in[11:0];
            ADDR_STARTF: startf_nxt = pwdata_in[11:0];
            ADDR_DELAY:  dly_nxt    = (pwdata_in[5:0] > BRK_DLY_MAX) ? BRK_DLY_MAX : pwdata_in[5:0];
            ADDR_FORCE:  force_nxt  = (pwdata_in[6:0] > BRK_FORCE_MAX) ? BRK_FORCE_MAX : pwdata_in[6:0];
            ADDR_OSET:   oset_nxt   = pwdata_in[11:0];
            ADDR_TFN:    tfn_nxt    = pwdata_in[29:0];
            default:     slot_we    = (paddr_in[7:6] == SLOT_PAGE);
         endcase
      end
      if (key_w & pwdata_in[KEY_STORE] & (st_r == ST_STOP))
      begin
         slot_we  = 1'b1;
         slot_idx = sel;
         slot_dat = oset_r;
      end
   end

   // Run key latch; a press in the same cycle as a clear wins
   always_comb
   begin
      key_run_nxt = key_run_r;
      if (key_clr | (key_w & pwdata_in[KEY_STOP]))
      begin
         key_run_nxt = 1'b0;
      end
      if (key_w & pwdata_in[KEY_RUN])
      begin
         key_run_nxt = 1'b1;
      end
   end

   // Read data is captured in the setup cycle
   always_comb
   begin
      prdata_nxt = prdata_r;
      if (setup)
      begin
         case (paddr_in)
            ADDR_CTRL:   prdata_nxt = {26'h0, meth_r, 2'h0, src_r};
            ADDR_JOGF:   prdata_nxt = {20'h0, jogf_r};
            ADDR_STARTF: prdata_nxt = {20'h0, startf_r};
            ADDR_DELAY:  prdata_nxt = {26'h0, dly_r};
            ADDR_FORCE:  prdata_nxt = {25'h0, force_r};
            ADDR_OSET:   prdata_nxt = {20'h0, oset_r};
            ADDR_MON:    prdata_nxt = {20'h0, freq_r};
            ADDR_STATUS: prdata_nxt = {16'h0, sel, brk_t, jog_t, key_run_r, run_r, 2'h0, st_r};
            ADDR_TFN:    prdata_nxt = {2'h0, tfn_r};
            default:     prdata_nxt = (paddr_in[7:6] == SLOT_PAGE) ? {20'h0, slot_r[paddr_in[5:2]]} : 32'h0;
         endcase
      end
   end

   // Drive sequencing
   always_comb
   begin
      st_nxt    = st_r;
      freq_nxt  = freq_r;
      cnt_nxt   = cnt_r;
      timed_nxt = timed_r;
      key_clr   = 1'b0;
      case (st_r)
         ST_STOP:
         begin
            freq_nxt = 12'h000;
            if (run_req & jog_t & jog_ok)
            begin
               st_nxt   = ST_JOG;
               freq_nxt = jog_lim;
            end
            else if (run_req & ~jog_t)
            begin
               st_nxt = ST_RUN;
            end
         end
         ST_RUN, ST_DECEL:
         begin
            if (brk_t)
            begin
               freq_nxt  = 12'h000;
               timed_nxt = 1'b0;
               cnt_nxt   = dly_r;
               st_nxt    = (dly_r == 6'h00) ? ST_BRAKE : ST_WAIT;
            end
            else if (run_req & ~jog_t)
            begin
               st_nxt   = ST_RUN;
               freq_nxt = ms_tick ? fn_step(freq_r, target) : freq_r;
            end
            else if (freq_r == 12'h000)
            begin
               st_nxt = ST_STOP;
            end
            else
            begin
               st_nxt   = ST_DECEL;
               freq_nxt = ms_tick ? freq_r - 12'h001 : freq_r;
            end
         end
         ST_JOG:
         begin
            freq_nxt = jog_lim;
            if (~run_req | ~jog_t | ~jog_ok | brk_t)
            begin
               case (meth_r)
                  STOP_DECEL:
                  begin
                     st_nxt = ST_DECEL;
                  end
                  STOP_DCBRAKE:
                  begin
                     st_nxt    = ST_BRAKE;
                     freq_nxt  = 12'h000;
                     timed_nxt = 1'b1;
                     cnt_nxt   = (dly_r == 6'h00) ? BRK_DLY_MIN : dly_r;
                  end
                  default:
                  begin
                     st_nxt   = ST_STOP;
                     freq_nxt = 12'h000;
                  end
               endcase
            end
         end
         ST_WAIT, ST_BRAKE:
         begin
            freq_nxt = 12'h000;
            if (timed_r)
            begin
               if (cnt_r == 6'h00)
               begin
                  st_nxt    = ST_STOP;
                  timed_nxt = 1'b0;
               end
               else if (tenth_tick)
               begin
                  cnt_nxt = cnt_r - 6'h01;
               end
            end
            else if (~brk_t)
            begin
               if (term_run)
               begin
                  st_nxt = ST_RUN;
               end
               else
               begin
                  st_nxt  = ST_STOP;
                  key_clr = 1'b1;
               end
            end
            else if (st_r == ST_WAIT)
            begin
               if (cnt_r == 6'h00)
               begin
                  st_nxt = ST_BRAKE;
               end
               else if (tenth_tick)
               begin
                  cnt_nxt = cnt_r - 6'h01;
               end
            end
         end
         default:
         begin
            st_nxt   = ST_STOP;
            freq_nxt = 12'h000;
         end
      endcase
      run_nxt = (st_nxt == ST_RUN) | (st_nxt == ST_JOG) | (st_nxt == ST_DECEL);
      lvl_nxt = (st_nxt == ST_BRAKE) ? force_nxt : 7'h00;
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         s1_r      <= 7'h00;
         s2_r      <= 7'h00;
         s3_r      <= 7'h00;
         pin_r     <= 7'h00;
         src_r     <= RST_SRC;
         meth_r    <= RST_METH;
         jogf_r    <= RST_JOGF;
         startf_r  <= RST_STARTF;
         dly_r     <= RST_DELAY;
         force_r   <= RST_FORCE;
         oset_r    <= RST_OSET;
         tfn_r     <= RST_TFN;
         for (int i = 0; i < 16; i++)
         begin
            slot_r[i] <= 12'h000;
         end
         st_r      <= ST_STOP;
         freq_r    <= 12'h000;
         cnt_r     <= 6'h00;
         timed_r   <= 1'b0;
         key_run_r <= 1'b0;
         run_r     <= 1'b0;
         lvl_r     <= 7'h00;
         ms_r      <= 15'h0000;
         tenth_r   <= 7'h00;
         prdata_r  <= 32'h0;
      end
      else
      begin
         s1_r      <= {reverse_run_in, forward_run_in, term_in};
         s2_r      <= s1_r;
         s3_r      <= s2_r;
         pin_r     <= pin_nxt;
         src_r     <= src_nxt;
         meth_r    <= meth_nxt;
         jogf_r    <= jogf_nxt;
         startf_r  <= startf_nxt;
         dly_r     <= dly_nxt;
         force_r   <= force_nxt;
         oset_r    <= oset_nxt;
         tfn_r     <= tfn_nxt;
         if (slot_we)
         begin
            slot_r[slot_idx] <= slot_dat;
         end
         st_r      <= st_nxt;
         freq_r    <= freq_nxt;
         cnt_r     <= cnt_nxt;
         timed_r   <= timed_nxt;
         key_run_r <= key_run_nxt;
         run_r     <= run_nxt;
         lvl_r     <= lvl_nxt;
         ms_r      <= ms_nxt;
         tenth_r   <= tenth_nxt;
         prdata_r  <= prdata_nxt;
      end
   end

   a_jog_freq_cap: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (st_r == ST_JOG) |-> (freq_out <= JOG_LIMIT && freq_out == jog_lim)) else $error("jog frequency above cap");
   a_jog_start_out: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (st_r == ST_STOP && run_req && jog_t && jog_ok) |=> (st_r == ST_JOG && run_out && freq_out == $past(jog_lim)))
      else $error("jog start did not output jog frequency");
   a_key_jog_src: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (st_r == ST_STOP && !term_run && src_r != SRC_TERMINAL && jog_t) |=> (st_r != ST_JOG))
      else $error("keypad run started jog outside terminal mode");
   a_jog_coast_end: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (st_r == ST_JOG && (!jog_t || !run_req) && meth_r == STOP_COAST) |=>
      (st_r == ST_STOP && freq_out == 12'h000 && !run_out))
      else $error("jog coast stop wrong");
   a_jog_blocked: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (st_r == ST_STOP && !jog_ok) |=> (st_r != ST_JOG)) else $error("jog ran with invalid jog frequency");
   a_jog_off_stop: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (st_r == ST_JOG && !jog_t) |=> (st_r != ST_JOG)) else $error("jog kept running after jog input off");
   a_brake_force: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (st_r == ST_BRAKE) |-> (brake_level_out == force_r && freq_out == 12'h000)) else $error("brake level wrong");
   a_brake_coast: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (st_r == ST_WAIT && brk_t && cnt_r != 6'h00) |=> (st_r == ST_WAIT && brake_level_out == 7'h00 && !run_out))
      else $error("braking began before delay expired");
   a_brake_resume: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (st_r == ST_BRAKE && !timed_r && !brk_t && term_run) |=> (st_r == ST_RUN ##1 run_out))
      else $error("terminal run did not resume after brake");
   a_brake_keypad: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (st_r == ST_BRAKE && !timed_r && !brk_t && !term_run) |=> (st_r == ST_STOP && !run_out))
      else $error("keypad run resumed after brake");
   a_monitor_read: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (setup && paddr_in == ADDR_MON) |=> (prdata_out == {20'h0, $past(freq_r)})) else $error("monitor read wrong");
   a_store_slot: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (st_r == ST_STOP && key_w && pwdata_in[KEY_STORE]) |=> (slot_r[$past(sel)] == $past(oset_r)))
      else $error("store key did not save slot");
endmodule

// ==== design/djb_pkg.sv ====
// Constants, register map and state codes for the jog and DC brake control block
package djb_pkg;
   localparam int FREQ_W           = 12;             // Frequency in 0.1 Hz units
   localparam int FREQ_SCALE       = 10;             // Units per hertz
   localparam int JOG_LIMIT_HZ     = 10;
   localparam logic [11:0] JOG_LIMIT = 12'(JOG_LIMIT_HZ * FREQ_SCALE);
   localparam int CLK_PERIOD_NS    = 40;
   localparam int RAMP_TICK_NS     = 1000000;        // One ramp step per millisecond
   localparam int RAMP_TICK_CYCLES = RAMP_TICK_NS / CLK_PERIOD_NS;
   localparam int TENTH_NS         = 100000000;      // Brake delay unit, 0.1 s
   localparam int TICKS_PER_TENTH  = TENTH_NS / RAMP_TICK_NS;
   localparam logic [5:0] BRK_DLY_MAX = 6'h32;       // 5.0 s in tenths
   localparam logic [5:0] BRK_DLY_MIN = 6'h01;       // 0.1 s in tenths
   localparam logic [6:0] BRK_FORCE_MAX = 7'h64;     // 100 percent
   localparam logic [1:0] SRC_TERMINAL = 2'h1;
   localparam logic [1:0] SRC_KEYPAD   = 2'h2;
   localparam logic [1:0] STOP_COAST   = 2'h0;
   localparam logic [1:0] STOP_DECEL   = 2'h1;
   localparam logic [1:0] STOP_DCBRAKE = 2'h2;
   localparam logic [5:0] FN_SEL0  = 6'h02;          // Select bits use codes 02 to 05
   localparam logic [5:0] FN_JOG   = 6'h06;
   localparam logic [5:0] FN_BRAKE = 6'h07;
   localparam int SRC_LSB  = 0;
   localparam int METH_LSB = 4;
   localparam int KEY_RUN   = 0;
   localparam int KEY_STOP  = 1;
   localparam int KEY_STORE = 2;
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_JOGF   = 8'h04;
   localparam logic [7:0] ADDR_STARTF = 8'h08;
   localparam logic [7:0] ADDR_DELAY  = 8'h0c;
   localparam logic [7:0] ADDR_FORCE  = 8'h10;
   localparam logic [7:0] ADDR_OSET   = 8'h14;
   localparam logic [7:0] ADDR_MON    = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1c;
   localparam logic [7:0] ADDR_TFN    = 8'h20;
   localparam logic [7:0] ADDR_KEY    = 8'h24;
   localparam logic [1:0] SLOT_PAGE   = 2'h1;        // Slots at 0x40 to 0x7c
   localparam logic [1:0]  RST_SRC    = 2'h1;
   localparam logic [1:0]  RST_METH   = 2'h1;
   localparam logic [11:0] RST_JOGF   = 12'h032;
   localparam logic [11:0] RST_STARTF = 12'h005;
   localparam logic [5:0]  RST_DELAY  = 6'h00;
   localparam logic [6:0]  RST_FORCE  = 7'h00;
   localparam logic [11:0] RST_OSET   = 12'h000;
   localparam logic [29:0] RST_TFN    = 30'h041c60c2;
   typedef enum logic [5:0] {
      ST_STOP  = 6'h01,
      ST_RUN   = 6'h02,
      ST_JOG   = 6'h04,
      ST_DECEL = 6'h08,
      ST_WAIT  = 6'h10,
      ST_BRAKE = 6'h20
   } djb_state_type;
endpackage

// ==== tb/djb_switch_model.sv ====
// Operator switch panel model driving the drive's input terminals
`timescale 1ns/100ps
module djb_switch_model (
   input  wire logic       ref_clk_in, // Bench clock
   input  wire logic       run_in,     // Drive output active
   input  wire logic       jog_in,     // Requested jog switch
   input  wire logic       brake_in,   // Requested brake switch
   input  wire logic [2:0] sel_in,     // Requested speed select
   output logic      [4:0] term_out,   // Terminal levels
   output logic            jog_out     // Jog switch as applied
);
   logic        brake_r = 1'b0;
   logic        jog_r   = 1'b0;
   logic [11:0] hold_r  = 12'h000;
   always_ff @(posedge ref_clk_in)
   begin
      if (!run_in)
         jog_r <= jog_in;
      hold_r  <= brake_in ? hold_r + 12'h001 : 12'h000;
      brake_r <= brake_in && (hold_r != 12'hfff);
   end
   assign term_out = {sel_in[2], brake_r, jog_r, sel_in[1:0]};
   assign jog_out  = jog_r;
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the jog and DC brake control block
`timescale 1ns/100ps
module testbench;
   import djb_pkg::*;
   logic        clk     = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic        fwd_run = 1'b0;
   logic        rev_run = 1'b0;
   logic        jog     = 1'b0;
   logic        brk     = 1'b0;
   logic [2:0]  sel     = 3'h0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, run;
   logic [4:0]  term;
   logic [11:0] freq;
   logic [6:0]  blev;
   logic [40:0] nt;
   logic [40:0] notes[$];
   int          err_count = 0;
   int          comparisons = 0;
   localparam logic [7:0]  RA[10] = '{ADDR_CTRL, ADDR_JOGF, ADDR_STARTF, ADDR_DELAY, ADDR_FORCE, ADDR_OSET,
                                      ADDR_TFN, ADDR_KEY, ADDR_STATUS, 8'h28};
   localparam logic [31:0] RSTV[10] = '{32'h11, 32'h32, 32'h5, 32'h0, 32'h0, 32'h0, 32'h041c60c2, 32'h0,
                                      32'h001, 32'h0};
   localparam logic [31:0] SV[3]  = '{32'h401, 32'h508, 32'h420};
   djb_drive_ctrl #(.RAMP_TICK_CYC(4)) djb_drive_ctrl_inst (.ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .term_in(term),
      .forward_run_in(fwd_run), .reverse_run_in(rev_run), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .freq_out(freq), .run_out(run), .brake_level_out(blev));
   djb_switch_model djb_switch_model_inst (.ref_clk_in(clk), .run_in(run), .jog_in(jog), .brake_in(brk),
      .sel_in(sel), .term_out(term), .jog_out());
   initial
   begin
      forever #20 clk = ~clk;
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er = 1'b0);
      notes.push_back({a, er, e});
      apb(a, 1'b0, 32'h0);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Read results are compared against the oldest note
   always @(posedge clk)
      if (psel && penable && pready === 1'b1 && !pwrite)
      begin
         if (notes.size() == 0)
            check("note queue", 32'h1, 32'h0);
         else
         begin
            nt = notes.pop_front();
            check($sformatf("read %h", nt[40:33]), prdata, nt[31:0]);
            check($sformatf("error %h", nt[40:33]), {31'h0, pslverr}, {31'h0, nt[32]});
         end
      end
   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      close_out();
   end
   initial
   begin
      int          m;
      logic [11:0] jf;
      logic [31:0] v;
      logic [31:0] w;
      void'($urandom(28646));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (RA[i])
         rd(RA[i], RSTV[i], RA[i] == 8'h28);
      $display("test 1 done");
      wr(ADDR_FORCE, 32'h7f);
      rd(ADDR_FORCE, 32'h64);
      jog <= 1'b1;
      for (m = 0; m < 3; m++)
      begin
         jf = (m == 0) ? 12'h096 : 12'h032;
         wr(ADDR_CTRL, 32'h01 | (m << 4));
         wr(ADDR_JOGF, {20'h0, jf});
         wr(ADDR_KEY, 32'h1);
         cyc(4);
         rd(ADDR_MON, (m == 0) ? 32'h64 : 32'h32);
         check("run output", {31'h0, run}, 32'h1);
         rd(ADDR_STATUS, 32'h704);
         wr(ADDR_KEY, 32'h2);
         cyc(4);
         rd(ADDR_STATUS, SV[m]);
         check("brake level", {25'h0, blev}, (m == 2) ? 32'h64 : 32'h0);
         cyc(900);
      end
      $display("test 2 done");
      for (m = 0; m < 3; m++)
      begin
         wr(ADDR_CTRL, (m == 0) ? 32'h12 : 32'h11);
         wr(ADDR_JOGF, (m == 0) ? 32'h32 : (m == 1) ? 32'h3 : 32'h0);
         wr(ADDR_KEY, 32'h1);
         cyc(4);
         rd(ADDR_STATUS, 32'h601);
         wr(ADDR_KEY, 32'h2);
      end
      jog <= 1'b0;
      cyc(8);
      $display("test 3 done");
      wr(ADDR_CTRL, 32'h11);
      wr(8'h40, 32'h20);
      fwd_run <= 1'b1;
      cyc(200);
      rd(ADDR_MON, 32'h20);
      brk <= 1'b1;
      cyc(8);
      rd(ADDR_STATUS, 32'h820);
      check("brake level", {25'h0, blev}, 32'h64);
      brk <= 1'b0;
      cyc(200);
      rd(ADDR_MON, 32'h20);
      wr(ADDR_DELAY, 32'h3f);
      rd(ADDR_DELAY, 32'h32);
      wr(ADDR_DELAY, 32'h2);
      brk <= 1'b1;
      cyc(100);
      rd(ADDR_STATUS, 32'h810);
      check("coast level", {25'h0, blev}, 32'h0);
      cyc(1200);
      rd(ADDR_STATUS, 32'h820);
      brk <= 1'b0;
      cyc(200);
      fwd_run <= 1'b0;
      cyc(300);
      $display("test 4 done");
      wr(ADDR_DELAY, 32'h0);
      wr(ADDR_CTRL, 32'h12);
      wr(ADDR_KEY, 32'h1);
      cyc(200);
      rd(ADDR_MON, 32'h20);
      brk <= 1'b1;
      cyc(8);
      brk <= 1'b0;
      cyc(8);
      rd(ADDR_STATUS, 32'h001);
      $display("test 5 done");
      wr(ADDR_CTRL, 32'h11);
      sel <= 3'h5;
      v = $urandom_range(64, 1);
      w = $urandom;
      wr(ADDR_OSET, v);
      wr(ADDR_KEY, 32'h4);
      rd(8'h54, v);
      wr(8'h7c, w);
      rd(8'h7c, {20'h0, w[11:0]});
      rev_run <= 1'b1;
      cyc(320);
      rd(ADDR_MON, v);
      check("output frequency", {20'h0, freq}, v);
      rev_run <= 1'b0;
      cyc(8);
      $display("test 6 done");
      close_out();
   end
endmodule
